// ### csa_pkg.sv
// Package with encodings, field positions and types for the command streamer ALU
package csa_pkg;

    // ------------------------------------------------------------
    // Instruction fields
    // ------------------------------------------------------------
    localparam int unsigned OPC_MSB   = 31;
    localparam int unsigned OPC_LSB   = 20;
    localparam int unsigned OPND1_MSB = 19;
    localparam int unsigned OPND1_LSB = 10;
    localparam int unsigned OPND2_MSB = 9;
    localparam int unsigned OPND2_LSB = 0;
    localparam int unsigned DATA_W    = 64;
    localparam int unsigned NUM_GPR   = 16;
    localparam int unsigned GPR_IDX_W = 4;

    // ------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------
    localparam logic [11:0] OP_NOOP      = 12'h000;
    localparam logic [11:0] OP_LOAD      = 12'h080;
    localparam logic [11:0] OP_FETCH_INV = 12'h480;
    localparam logic [11:0] OP_FETCH_0   = 12'h081;
    localparam logic [11:0] OP_FETCH_1   = 12'h481;
    localparam logic [11:0] OP_ADD       = 12'h100;
    localparam logic [11:0] OP_SUB       = 12'h101;
    localparam logic [11:0] OP_AND       = 12'h102;
    localparam logic [11:0] OP_OR        = 12'h103;
    localparam logic [11:0] OP_XOR       = 12'h104;
    localparam logic [11:0] OP_STORE     = 12'h180;
    localparam logic [11:0] OP_STORE_INV = 12'h580;

    // Opcode subfield positions and group values
    localparam int unsigned PFX_MSB  = 11;
    localparam int unsigned PFX_LSB  = 10;
    localparam int unsigned GRP_MSB  = 9;
    localparam int unsigned GRP_LSB  = 7;
    localparam int unsigned SUB_MSB  = 6;
    localparam int unsigned SUB_LSB  = 0;
    localparam logic [1:0] PFX_REG   = 2'h0;
    localparam logic [1:0] PFX_INV   = 2'h1;
    localparam logic [2:0] GRP_NOOP  = 3'h0;
    localparam logic [2:0] GRP_LOAD  = 3'h1;
    localparam logic [2:0] GRP_ALU   = 3'h2;
    localparam logic [2:0] GRP_STORE = 3'h3;

    // ------------------------------------------------------------
    // Operand encodings
    // ------------------------------------------------------------
    localparam logic [9:0] ENC_GPR_MAX = 10'h00F;
    localparam logic [9:0] ENC_SRC_A   = 10'h020;
    localparam logic [9:0] ENC_SRC_B   = 10'h021;
    localparam logic [9:0] ENC_ACC     = 10'h031;
    localparam logic [9:0] ENC_ZF      = 10'h032;
    localparam logic [9:0] ENC_CF      = 10'h033;

    localparam logic [63:0] ACC_RST = 64'h0000_0000_0000_0000;

    typedef struct packed {
        logic [11:0] opcode;
        logic [9:0]  opnd1;
        logic [9:0]  opnd2;
    } csa_instr_t;

    typedef struct packed {
        logic [3:0]  idx;
        logic [63:0] data;
    } csa_gpr_wr_t;

endpackage : csa_pkg

// ### csa_alu.sv
// Command streamer ALU: general registers, operand registers, accumulator
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Functional notes
// - Add, subtract, AND, OR, XOR on 64 bits
// - Two operand registers, one 64-bit accumulator
// - Zero and carry flags follow each operation
// - Sixteen 64-bit general registers, externally accessible
// - Instruction: opcode, operand one, operand two
// - Load copies general into operand register
// - Fetch inverted loads complemented general register
// - Fetch zeros or ones ignores operand two
// - Opcodes add and subtract update flags
// - Opcodes AND, OR, XOR into accumulator
// - No-op changes nothing
// - Store copies accumulator or flag to general
// - Inverted store writes complemented value
// - Stored flag replicated over 64 bits
// - Opcode splits into prefix, group, subopcode
// - Operand encodings for registers and flags
// ----------------------------------------------------------------
module csa_alu (
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire logic                 clk_en,
    input  wire logic                 instr_valid,
    input  wire csa_pkg::csa_instr_t  instr,
    input  wire logic                 mmio_wr_en,
    input  wire csa_pkg::csa_gpr_wr_t mmio_wr,
    input  wire logic [3:0]           mmio_rd_idx,
    output logic [63:0]               mmio_rd_data,
    output logic [63:0]               operand_a_reg,
    output logic [63:0]               operand_b_reg,
    output logic [63:0]               result_accumulator,
    output logic                      zero_flag,
    output logic                      carry_flag
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [63:0] gpr_ff [csa_pkg::NUM_GPR];
    logic [63:0] src_a_ff;
    logic [63:0] src_b_ff;
    logic [63:0] acc_ff;
    logic        zf_ff;
    logic        cf_ff;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // opcode subfields
    wire [1:0] pfx = instr.opcode[csa_pkg::PFX_MSB:csa_pkg::PFX_LSB];
    wire [2:0] grp = instr.opcode[csa_pkg::GRP_MSB:csa_pkg::GRP_LSB];
    wire [6:0] sub = instr.opcode[csa_pkg::SUB_MSB:csa_pkg::SUB_LSB];
    wire       go  = instr_valid & clk_en;

    function automatic logic is_gpr(input logic [9:0] enc);
        is_gpr = (enc <= csa_pkg::ENC_GPR_MAX);
    endfunction : is_gpr

    function automatic logic is_src(input logic [9:0] enc);
        is_src = (enc == csa_pkg::ENC_SRC_A) | (enc == csa_pkg::ENC_SRC_B);
    endfunction : is_src

    // Subopcode match, shared by the five ALU ops
    function automatic logic sub_is(input logic [6:0]  s,
                                    input logic [11:0] opc);
        sub_is = (s == opc[csa_pkg::SUB_MSB:csa_pkg::SUB_LSB]);
    endfunction : sub_is

    wire [3:0]  g1_idx  = instr.opnd1[3:0];
    wire [3:0]  g2_idx  = instr.opnd2[3:0];
    wire [63:0] g2_data = gpr_ff[g2_idx];
    wire        dst_b   = (instr.opnd1 == csa_pkg::ENC_SRC_B);

    wire op_load  = go & (instr.opcode == csa_pkg::OP_LOAD);
    wire op_ldinv = go & (instr.opcode == csa_pkg::OP_FETCH_INV);
    wire op_ld0   = go & (instr.opcode == csa_pkg::OP_FETCH_0);
    wire op_ld1   = go & (instr.opcode == csa_pkg::OP_FETCH_1);
    wire ld_any   = ((op_load | op_ldinv) & is_gpr(instr.opnd2)
                    | op_ld0 | op_ld1) & is_src(instr.opnd1);
    wire [63:0] ld_val = op_ld0   ? '0 :
                         op_ld1   ? '1 :
                         op_ldinv ? ~g2_data : g2_data;

    wire [64:0] sum   = {1'b0, src_a_ff} + {1'b0, src_b_ff};
    wire [64:0] diff  = {1'b0, src_a_ff} - {1'b0, src_b_ff};
    wire alu_grp      = go & (pfx == csa_pkg::PFX_REG)
                        & (grp == csa_pkg::GRP_ALU);
    wire op_add = alu_grp & sub_is(sub, csa_pkg::OP_ADD);
    wire op_sub = alu_grp & sub_is(sub, csa_pkg::OP_SUB);
    wire op_and = alu_grp & sub_is(sub, csa_pkg::OP_AND);
    wire op_or  = alu_grp & sub_is(sub, csa_pkg::OP_OR);
    wire op_xor = alu_grp & sub_is(sub, csa_pkg::OP_XOR);
    wire alu_any = op_add | op_sub | op_and | op_or | op_xor;
    wire [64:0] alu_res = op_add ? sum :
                          op_sub ? diff :
                          op_and ? {1'b0, src_a_ff & src_b_ff} :
                          op_or  ? {1'b0, src_a_ff | src_b_ff} :
                                   {1'b0, src_a_ff ^ src_b_ff};
    wire nxt_zf = (alu_res[63:0] == 64'h0000_0000_0000_0000);
    wire nxt_cf = alu_res[64];

    wire op_st  = go & (instr.opcode == csa_pkg::OP_STORE);
    wire op_sti = go & (instr.opcode == csa_pkg::OP_STORE_INV);
    wire st_src = (instr.opnd2 == csa_pkg::ENC_ACC)
                  | (instr.opnd2 == csa_pkg::ENC_ZF)
                  | (instr.opnd2 == csa_pkg::ENC_CF);
    wire st_any = (op_st | op_sti) & is_gpr(instr.opnd1) & st_src;
    wire [63:0] st_raw = (instr.opnd2 == csa_pkg::ENC_ACC) ? acc_ff :
                         (instr.opnd2 == csa_pkg::ENC_ZF)  ? {64{zf_ff}} :
                                                             {64{cf_ff}};
    wire [63:0] st_val = op_sti ? ~st_raw : st_raw;

    // ------------------------------------------------------------
    // General registers
    // ------------------------------------------------------------
    // external write loses to a same-cycle store
    genvar gi;
    generate
        for (gi = 0; gi < csa_pkg::NUM_GPR; gi++) begin : g_gpr
            wire st_hit = st_any & (g1_idx == 4'(gi));
            wire mm_hit = clk_en & mmio_wr_en & (mmio_wr.idx == 4'(gi));
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    gpr_ff[gi] <= csa_pkg::ACC_RST;
                end else if (st_hit) begin
                    gpr_ff[gi] <= st_val;
                end else if (mm_hit) begin
                    gpr_ff[gi] <= mmio_wr.data;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Operand registers, accumulator, flags
    // ------------------------------------------------------------
    // operand and accumulator state, single-cycle commit
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            src_a_ff <= csa_pkg::ACC_RST;
            src_b_ff <= csa_pkg::ACC_RST;
            acc_ff   <= csa_pkg::ACC_RST;
            zf_ff    <= 1'b0;
            cf_ff    <= 1'b0;
        end else begin
            if (ld_any && !dst_b) begin
                src_a_ff <= ld_val;
            end
            if (ld_any && dst_b) begin
                src_b_ff <= ld_val;
            end
            if (alu_any) begin
                acc_ff <= alu_res[63:0];
                zf_ff  <= nxt_zf;
                cf_ff  <= nxt_cf;
            end
        end
    end

    // Read port registered so data outputs come from flip-flops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mmio_rd_data <= csa_pkg::ACC_RST;
        end else if (clk_en) begin
            mmio_rd_data <= gpr_ff[mmio_rd_idx];
        end
    end

    assign operand_a_reg      = src_a_ff;
    assign operand_b_reg      = src_b_ff;
    assign result_accumulator = acc_ff;
    assign zero_flag          = zf_ff;
    assign carry_flag         = cf_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_add_issue;
        op_add;
    endsequence

    property p_add;
        @(posedge clk) disable iff (!rst_b)
        s_add_issue |=> acc_ff == $past(src_a_ff) + $past(src_b_ff);
    endproperty
    a_add: assert property (p_add) else $error("add wrong");

    property p_sub_cf;
        @(posedge clk) disable iff (!rst_b)
        op_sub |=> cf_ff == ($past(src_a_ff) < $past(src_b_ff));
    endproperty
    a_sub_cf: assert property (p_sub_cf) else $error("borrow wrong");

    property p_xor;
        @(posedge clk) disable iff (!rst_b)
        op_xor |=> acc_ff == ($past(src_a_ff) ^ $past(src_b_ff));
    endproperty
    a_xor: assert property (p_xor) else $error("xor wrong");

    property p_zf;
        @(posedge clk) disable iff (!rst_b)
        alu_any |=> zf_ff == (acc_ff == 64'h0000_0000_0000_0000);
    endproperty
    a_zf: assert property (p_zf) else $error("zero flag wrong");

    property p_ld1;
        @(posedge clk) disable iff (!rst_b)
        (op_ld1 && instr.opnd1 == csa_pkg::ENC_SRC_A) |=> src_a_ff == '1;
    endproperty
    a_ld1: assert property (p_ld1) else $error("fetch ones wrong");

    property p_ldinv;
        @(posedge clk) disable iff (!rst_b)
        (ld_any && op_ldinv && dst_b) |=> src_b_ff == ~$past(g2_data);
    endproperty
    a_ldinv: assert property (p_ldinv) else $error("fetch inv wrong");

    property p_stflag;
        @(posedge clk) disable iff (!rst_b)
        (st_any && op_st && instr.opnd2 == csa_pkg::ENC_CF)
        |=> gpr_ff[$past(g1_idx)] == {64{cf_ff}};
    endproperty
    a_stflag: assert property (p_stflag) else $error("flag store");

    property p_noop;
        @(posedge clk) disable iff (!rst_b)
        (go && instr.opcode == csa_pkg::OP_NOOP)
        |=> $stable(acc_ff) && $stable(src_a_ff) && $stable(cf_ff);
    endproperty
    a_noop: assert property (p_noop) else $error("noop changed");

endmodule : csa_alu

// ### csa_parser_model.sv
// Parser model that hands instruction dwords to the ALU
`timescale 1ns/10ps
module csa_parser_model (
    input  wire logic           clk,
    input  wire logic           rst_b,
    input  wire logic           issue,
    input  wire logic [31:0]    word,
    output logic                instr_valid,
    output csa_pkg::csa_instr_t instr
);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            instr_valid <= 1'b0;
            instr       <= '0;
        end else if (issue) begin
            instr_valid <= 1'b1;
            instr       <= word;
        end else begin
            // Idle word scrambled so stale data is never trusted
            instr_valid <= 1'b0;
            instr       <= ~instr;
        end
    end
endmodule : csa_parser_model

// ### cmd_stream_alu_tb_top.sv
// Self-checking bench for the command streamer ALU
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
    err_total++; $display("mismatch %s exp %h got %h", n, e, g); end end
module cmd_stream_alu_tb_top;
    logic clk, rst_b, clk_en, issue, instr_valid, mmio_wr_en, zf, cf;
    logic [31:0] word;
    logic [3:0]  mmio_rd_idx;
    logic [63:0] mmio_rd_data, opa, opb, acc, r_a, r_b, r_acc;
    logic [63:0] r_gpr [16];
    logic        r_zf, r_cf;
    int          err_total, checks_done;
    csa_pkg::csa_instr_t  instr;
    csa_pkg::csa_gpr_wr_t mmio_wr;
    logic [31:0] seq [16] = '{
        {12'h080, 10'h020, 10'h001}, {12'h080, 10'h021, 10'h002},
        {12'h100, 10'h000, 10'h000}, {12'h180, 10'h005, 10'h033},
        {12'h580, 10'h006, 10'h032}, {12'h101, 10'h3FF, 10'h3FF},
        {12'h180, 10'h007, 10'h031}, {12'h480, 10'h021, 10'h003},
        {12'h081, 10'h020, 10'h3FF}, {12'h101, 10'h000, 10'h000},
        {12'h104, 10'h000, 10'h000}, {12'h481, 10'h021, 10'h2AA},
        {12'h000, 10'h020, 10'h001}, {12'h7FF, 10'h020, 10'h001},
        {12'h180, 10'h009, 10'h020}, {12'h500, 10'h000, 10'h000}};
    logic [11:0] ops [13] = '{12'h000, 12'h080, 12'h480, 12'h081,
        12'h481, 12'h100, 12'h101, 12'h102, 12'h103, 12'h104, 12'h180,
        12'h580, 12'h0FF};

    csa_parser_model u_csa_parser_model (.clk(clk), .rst_b(rst_b),
        .issue(issue), .word(word), .instr_valid(instr_valid),
        .instr(instr));
    csa_alu u_csa_alu (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
        .instr_valid(instr_valid), .instr(instr),
        .mmio_wr_en(mmio_wr_en), .mmio_wr(mmio_wr),
        .mmio_rd_idx(mmio_rd_idx), .mmio_rd_data(mmio_rd_data),
        .operand_a_reg(opa), .operand_b_reg(opb),
        .result_accumulator(acc), .zero_flag(zf), .carry_flag(cf));

    // ------------------------------------------------------------
    // Reference model
    // ------------------------------------------------------------
    task automatic ref_step(input logic [31:0] w);
        logic [11:0] op;
        logic [9:0]  d;
        logic [9:0]  s;
        logic [63:0] v;
        op = w[31:20];
        d = w[19:10];
        s = w[9:0];
        v = op[0] ? {64{op[10]}} : (op[10] ? ~r_gpr[s[3:0]] : r_gpr[s[3:0]]);
        case (op)
        12'h080, 12'h480, 12'h081, 12'h481: begin
            if (s <= 10'h00F || op[0]) begin
                if (d == 10'h020) r_a = v;
                if (d == 10'h021) r_b = v;
            end
        end
        12'h100, 12'h101, 12'h102, 12'h103, 12'h104: begin
            case (op[2:0])
            3'h0: {r_cf, r_acc} = {1'b0, r_a} + {1'b0, r_b};
            3'h1: {r_cf, r_acc} = {r_a < r_b, r_a - r_b};
            3'h2: {r_cf, r_acc} = {1'b0, r_a & r_b};
            3'h3: {r_cf, r_acc} = {1'b0, r_a | r_b};
            default: {r_cf, r_acc} = {1'b0, r_a ^ r_b};
            endcase
            r_zf = (r_acc == 64'h0);
        end
        12'h180, 12'h580: begin
            v = (s == 10'h031) ? r_acc : {64{(s == 10'h032) ? r_zf : r_cf}};
            if (d <= 10'h00F && s >= 10'h031 && s <= 10'h033)
                r_gpr[d[3:0]] = op[10] ? ~v : v;
        end
        default: ;
        endcase
    endtask : ref_step

    task automatic ref_clear();
        foreach (r_gpr[i]) r_gpr[i] = 64'h0;
        {r_a, r_b, r_acc, r_zf, r_cf} = '0;
    endtask : ref_clear

    // ------------------------------------------------------------
    // Drivers and comparison
    // ------------------------------------------------------------
    task automatic exec(input logic [31:0] w, input bit apply);
        @(posedge clk);
        issue <= 1'b1;
        word  <= w;
        if (apply) ref_step(w);
    endtask : exec

    task automatic mw(input logic [3:0] i, input logic [63:0] d);
        @(posedge clk);
        mmio_wr_en <= 1'b1;
        mmio_wr    <= '{idx: i, data: d};
        r_gpr[i] = d;
        @(posedge clk);
        mmio_wr_en <= 1'b0;
    endtask : mw

    task automatic cmp_all();
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            mmio_rd_idx <= 4'(i);
            @(posedge clk);
            #1;
            `CHK("gpr", r_gpr[i], mmio_rd_data)
        end
        `CHK("operand_a", r_a, opa)
        `CHK("operand_b", r_b, opb)
        `CHK("accumulator", r_acc, acc)
        `CHK("zero_flag", r_zf, zf)
        `CHK("carry_flag", r_cf, cf)
    endtask : cmp_all

    task automatic settle();
        @(posedge clk);
        issue <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : settle

    function automatic logic [9:0] rnd_opnd();
        case ($urandom % 8)
        0: return 10'h020;
        1: return 10'h021;
        2: return 10'h031;
        3: return 10'h032;
        4: return 10'h033;
        5: return 10'($urandom);
        default: return 10'($urandom % 16);
        endcase
    endfunction : rnd_opnd

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Watchdog well beyond the expected few thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        complete_run();
    end

    initial begin
        {rst_b, clk_en, issue, mmio_wr_en} = 4'h4;
        {word, mmio_rd_idx} = '0;
        mmio_wr = '0;
        {err_total, checks_done} = '0;
        ref_clear();
        void'($urandom(32'hB9AA75B8));
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        cmp_all();
        mw(4'h1, 64'hFFFF_FFFF_FFFF_FFFF);
        mw(4'h2, 64'h0000_0000_0000_0001);
        mw(4'h3, 64'h8000_0000_0000_0000);
        foreach (seq[i]) exec(seq[i], 1'b1);
        settle();
        cmp_all();
        // store beats a same-cycle external write
        exec({12'h180, 10'h009, 10'h031}, 1'b1);
        @(posedge clk);
        issue      <= 1'b0;
        mmio_wr_en <= 1'b1;
        mmio_wr    <= '{idx: 4'h9, data: 64'h0123_4567_89AB_CDEF};
        @(posedge clk);
        mmio_wr_en <= 1'b0;
        settle();
        cmp_all();
        // Frozen clock enable drops the instruction
        @(posedge clk);
        clk_en <= 1'b0;
        exec({12'h481, 10'h020, 10'h000}, 1'b0);
        settle();
        clk_en <= 1'b1;
        cmp_all();
        repeat (40) begin
            mw(4'($urandom), {$urandom, $urandom});
            repeat (8) exec({ops[$urandom % 13], rnd_opnd(), rnd_opnd()}, 1);
            settle();
            cmp_all();
        end
        // Second reset in mid-run clears everything
        @(posedge clk);
        rst_b <= 1'b0;
        @(posedge clk);
        rst_b <= 1'b1;
        ref_clear();
        cmp_all();
        complete_run();
    end
endmodule : cmd_stream_alu_tb_top
